// ---- rtl/ext_pin_irq_pkg.sv ----
package ext_pin_irq_pkg;

   // Bus geometry
   localparam int ADR_W      = 8;             // Byte address width seen by the slave
   localparam int DAT_W      = 32;            // Wishbone data width
   localparam int SEL_W      = DAT_W / 8;     // One select bit per byte lane
   localparam int WORD_LSB   = 2;             // Word index starts above the byte offset

   // Pin counts
   localparam int PORT_PINS  = 16;            // Level-sensed port interrupt pins
   localparam int GROUP_SIZE = 8;             // Port pins folded into one group flag
   localparam int IRQ_LINES  = 6;             // Sense-selectable IRQ lines
   localparam int MODE_W     = 2;             // Width of one IRQ line sense field
   localparam int CTRL_W     = IRQ_LINES * MODE_W;
   localparam int REQ_W      = 8;             // Request, status and mask width

   // Register byte offsets
   localparam logic [ADR_W-1:0] OFF_SENSE  = 8'h00;  // port_pin_sense_select
   localparam logic [ADR_W-1:0] OFF_ENABLE = 8'h04;  // port_pin_interrupt_enable
   localparam logic [ADR_W-1:0] OFF_REQ    = 8'h08;  // pin_request_flags
   localparam logic [ADR_W-1:0] OFF_CTRL   = 8'h0c;  // irq_pin_control sense fields
   localparam logic [ADR_W-1:0] OFF_STATUS = 8'h10;  // Sticky event status, read clears
   localparam logic [ADR_W-1:0] OFF_MASK   = 8'h14;  // Interrupt mask, same layout

   // Field positions inside the request word
   localparam int REQ_LOW_GRP_BIT  = 7;       // Port pins 0 to 7
   localparam int REQ_HIGH_GRP_BIT = 6;       // Port pins 8 to 15

   // Reset values
   localparam logic [PORT_PINS-1:0] SENSE_RESET  = 16'h0000;
   localparam logic [PORT_PINS-1:0] ENABLE_RESET = 16'h0000;
   localparam logic [REQ_W-1:0]     REQ_RESET    = 8'h00;
   localparam logic [CTRL_W-1:0]    CTRL_RESET   = 12'h000;
   localparam logic [REQ_W-1:0]     MASK_RESET   = 8'h00;
   localparam logic [REQ_W-1:0]     STATUS_RESET = 8'h00;

   // IRQ line detection modes, in field encoding order
   typedef enum logic [MODE_W-1:0] {
      MODE_FALL,
      MODE_RISE,
      MODE_LOW,
      MODE_RSVD
   } line_mode_type;

   // Wishbone request from the master
   typedef struct packed {
      logic             cyc;
      logic             stb;
      logic             we;
      logic [ADR_W-1:0] adr;
      logic [SEL_W-1:0] sel;
      logic [DAT_W-1:0] dat;
   } wb_req_type;

   // Wishbone answer to the master
   typedef struct packed {
      logic             ack;
      logic [DAT_W-1:0] dat;
   } wb_rsp_type;

   // State of one IRQ line detector
   typedef struct packed {
      logic primed;                           // First sample after reset taken
      logic prev;                             // Pin level one clock ago
      logic flag;                             // Request flag
   } line_state_type;

   localparam line_state_type LINE_RESET = '0;

   // State of the top level
   typedef struct packed {
      logic [PORT_PINS-1:0] sense;
      logic [PORT_PINS-1:0] enable;
      logic [CTRL_W-1:0]    line_ctrl;
      logic [REQ_W-1:0]     mask;
      logic [REQ_W-1:0]     status;
      logic [REQ_W-1:0]     req_prev;
      logic [IRQ_LINES-1:0] armed;
      logic                 grp_low;
      logic                 grp_high;
      logic                 ack;
      logic [DAT_W-1:0]     rdata;
      logic                 irq;
   } main_state_type;

   localparam main_state_type MAIN_RESET = '0;

endpackage

// ---- rtl/irq_line_sense.sv ----
`timescale 1ns/1ps
`default_nettype none

module irq_line_sense (
   input  wire logic                          ref_clk,
   input  wire logic                          arst_n,
   input  wire logic                          clk_en,
   input  wire logic                          pin,
   input  wire ext_pin_irq_pkg::line_mode_type mode,
   input  wire logic                          clear,
   output logic                               flag
);

   ext_pin_irq_pkg::line_state_type st_reg;   // Registered detector state
   ext_pin_irq_pkg::line_state_type st_next;  // Its next value
   logic                            set_ev;   // Edge seen this clock

   // Edge detection and flag update
   always_comb begin
      st_next = st_reg;
      set_ev  = 1'b0;
      st_next.primed = 1'b1;
      st_next.prev   = pin;
      case (mode)
         ext_pin_irq_pkg::MODE_FALL: begin
            // Skipped until primed so a pin low at reset gives no false edge
            set_ev = st_reg.primed & st_reg.prev & ~pin;
            st_next.flag = set_ev | (st_reg.flag & ~clear);
         end
         ext_pin_irq_pkg::MODE_RISE: begin
            set_ev = st_reg.primed & ~st_reg.prev & pin;
            st_next.flag = set_ev | (st_reg.flag & ~clear);
         end
         ext_pin_irq_pkg::MODE_LOW: begin
            // Level mode follows the pin, a clear cannot stick
            st_next.flag = ~pin;
         end
         default: begin
            // Reserved code detects nothing but still honours a clear
            st_next.flag = st_reg.flag & ~clear;
         end
      endcase
   end

   // State register, frozen while the clock enable is low
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_reg <= ext_pin_irq_pkg::LINE_RESET;
      end else if (clk_en) begin
         st_reg <= st_next;
      end
   end

   assign flag = st_reg.flag;

   default clocking line_cb @(posedge ref_clk);
   endclocking
   default disable iff (!arst_n || !clk_en);

   a_fall_sets_flag: assert property (
      st_reg.primed && mode == ext_pin_irq_pkg::MODE_FALL && st_reg.prev && !pin
      |=> flag) else $error("falling edge did not set the flag");

   a_rise_sets_flag: assert property (
      st_reg.primed && mode == ext_pin_irq_pkg::MODE_RISE && !st_reg.prev && pin
      |=> flag) else $error("rising edge did not set the flag");

   a_edge_flag_holds: assert property (
      flag && !clear && (mode == ext_pin_irq_pkg::MODE_FALL ||
      mode == ext_pin_irq_pkg::MODE_RISE)
      |=> flag [*1]) else $error("edge flag dropped without a clear");

   a_edge_clear_drops: assert property (
      clear && !set_ev && (mode == ext_pin_irq_pkg::MODE_FALL ||
      mode == ext_pin_irq_pkg::MODE_RISE)
      |=> !flag) else $error("clear did not withdraw the edge request");

   a_level_follows_pin: assert property (
      mode == ext_pin_irq_pkg::MODE_LOW |=> flag == !$past(pin))
      else $error("low level flag does not follow the pin");

endmodule

`default_nettype wire

// ---- rtl/ext_pin_irq_detect.sv ----
// Contract
// - Port pin requests at level chosen by sense
// - Per-pin enable blocks or passes requests
// - Sense and enable reset to zero
// - Request register resets to zero
// - Bit 7 ORs requests of pins 0-7
// - Bit 6 ORs requests of pins 8-15
// - Bits 5-0 flag detected IRQ line requests
// - Writing one keeps flag; armed zero clears
// - Edge request pending until flag cleared
// - Sense field selects fall, rise, low level
`timescale 1ns/1ps
`default_nettype none

module ext_pin_irq_detect (
   input  wire logic                                       ref_clk,
   input  wire logic                                       arst_n,
   input  wire logic                                       clk_en,
   input  wire ext_pin_irq_pkg::wb_req_type                wb_req,
   output ext_pin_irq_pkg::wb_rsp_type                     wb_rsp,
   input  wire logic [ext_pin_irq_pkg::PORT_PINS-1:0]      port_irq_pin,
   input  wire logic [ext_pin_irq_pkg::IRQ_LINES-1:0]      irq_line,
   output logic                                            irq_out
);

   ext_pin_irq_pkg::main_state_type              st_reg;      // All registered state
   ext_pin_irq_pkg::main_state_type              st_next;     // Its next value
   logic [ext_pin_irq_pkg::PORT_PINS-1:0]        match_vec;   // Enabled pins at active level
   logic [ext_pin_irq_pkg::IRQ_LINES-1:0]        line_flag;   // Flags from the line detectors
   logic [ext_pin_irq_pkg::IRQ_LINES-1:0]        clear_vec;   // Accepted clears per line
   logic [ext_pin_irq_pkg::REQ_W-1:0]            req_now;     // Request word as read
   logic [ext_pin_irq_pkg::REQ_W-1:0]            event_vec;   // Rising request bits
   logic [ext_pin_irq_pkg::DAT_W-1:0]            rd_word;     // Read mux output
   logic                                         bus_req;     // Master holds a request
   logic                                         wr_acc;      // Write takes effect now
   logic                                         rd_acc;      // Read completes now
   logic                                         wr_req_hit;  // Write to the request word
   logic                                         hit_sense;
   logic                                         hit_enable;
   logic                                         hit_req;
   logic                                         hit_ctrl;
   logic                                         hit_status;
   logic                                         hit_mask;

   // Word address compare, byte offset ignored
   function automatic logic word_hit(
      input logic [ext_pin_irq_pkg::ADR_W-1:0] adr,
      input logic [ext_pin_irq_pkg::ADR_W-1:0] off
   );
      word_hit = adr[ext_pin_irq_pkg::ADR_W-1:ext_pin_irq_pkg::WORD_LSB] ==
                 off[ext_pin_irq_pkg::ADR_W-1:ext_pin_irq_pkg::WORD_LSB];
   endfunction

   // Merge a 16-bit write through the two low byte lanes
   function automatic logic [15:0] lane_merge(
      input logic [15:0] old_v,
      input logic [15:0] new_v,
      input logic [1:0]  lanes
   );
      lane_merge[7:0]  = lanes[0] ? new_v[7:0]  : old_v[7:0];
      lane_merge[15:8] = lanes[1] ? new_v[15:8] : old_v[15:8];
   endfunction

   // Address decode
   assign hit_sense  = word_hit(wb_req.adr, ext_pin_irq_pkg::OFF_SENSE);
   assign hit_enable = word_hit(wb_req.adr, ext_pin_irq_pkg::OFF_ENABLE);
   assign hit_req    = word_hit(wb_req.adr, ext_pin_irq_pkg::OFF_REQ);
   assign hit_ctrl   = word_hit(wb_req.adr, ext_pin_irq_pkg::OFF_CTRL);
   assign hit_status = word_hit(wb_req.adr, ext_pin_irq_pkg::OFF_STATUS);
   assign hit_mask   = word_hit(wb_req.adr, ext_pin_irq_pkg::OFF_MASK);

   // Bus phases: effects happen only on the edge where ack is seen high
   assign bus_req    = wb_req.cyc & wb_req.stb;
   assign wr_acc     = bus_req & st_reg.ack & wb_req.we;
   assign rd_acc     = bus_req & st_reg.ack & ~wb_req.we;
   assign wr_req_hit = wr_acc & hit_req & wb_req.sel[0];

   // Pin matches level chosen by its sense bit and is enabled
   assign match_vec = st_reg.enable & ~(port_irq_pin ^ st_reg.sense);

   // Request word: two group flags above six line flags
   assign req_now = {st_reg.grp_low, st_reg.grp_high, line_flag};
   assign event_vec = req_now & ~st_reg.req_prev;

   // Clear only bits written zero that were earlier read as one
   assign clear_vec = wr_req_hit ?
                      (st_reg.armed & ~wb_req.dat[ext_pin_irq_pkg::IRQ_LINES-1:0]) :
                      '0;

   // Read mux; unmapped words and unused upper bits read as zero
   always_comb begin
      rd_word = '0;
      if (hit_sense) begin
         rd_word[ext_pin_irq_pkg::PORT_PINS-1:0] = st_reg.sense;
      end else if (hit_enable) begin
         rd_word[ext_pin_irq_pkg::PORT_PINS-1:0] = st_reg.enable;
      end else if (hit_req) begin
         rd_word[ext_pin_irq_pkg::REQ_W-1:0] = req_now;
      end else if (hit_ctrl) begin
         rd_word[ext_pin_irq_pkg::CTRL_W-1:0] = st_reg.line_ctrl;
      end else if (hit_status) begin
         rd_word[ext_pin_irq_pkg::REQ_W-1:0] = st_reg.status;
      end else if (hit_mask) begin
         rd_word[ext_pin_irq_pkg::REQ_W-1:0] = st_reg.mask;
      end
   end

   // One detector per IRQ line, mode field taken from the control word
   genvar gi;
   generate
      for (gi = 0; gi < ext_pin_irq_pkg::IRQ_LINES; gi++) begin : g_line
         irq_line_sense u_sense (
            .ref_clk (ref_clk),
            .arst_n  (arst_n),
            .clk_en  (clk_en),
            .pin     (irq_line[gi]),
            .mode    (ext_pin_irq_pkg::line_mode_type'(
                        st_reg.line_ctrl[gi*ext_pin_irq_pkg::MODE_W +:
                                         ext_pin_irq_pkg::MODE_W])),
            .clear   (clear_vec[gi]),
            .flag    (line_flag[gi])
         );
      end
   endgenerate

   // Next-state logic for registers, bus answer and interrupt
   always_comb begin
      st_next = st_reg;

      // Ack one clock after the request, dropped after one clock
      st_next.ack = bus_req & ~st_reg.ack;
      if (bus_req && !st_reg.ack && !wb_req.we) begin
         // Capture what the master will see, so arming uses the same value
         st_next.rdata = rd_word;
      end

      // Group flags are resampled on every enabled clock
      st_next.grp_low  = |match_vec[ext_pin_irq_pkg::GROUP_SIZE-1:0];
      st_next.grp_high = |match_vec[ext_pin_irq_pkg::PORT_PINS-1:
                                    ext_pin_irq_pkg::GROUP_SIZE];

      // Writable registers through byte lanes
      if (wr_acc && hit_sense) begin
         st_next.sense = lane_merge(st_reg.sense, wb_req.dat[15:0], wb_req.sel[1:0]);
      end
      if (wr_acc && hit_enable) begin
         // Unused pins are expected to be left disabled by software
         st_next.enable = lane_merge(st_reg.enable, wb_req.dat[15:0], wb_req.sel[1:0]);
      end
      if (wr_acc && hit_ctrl) begin
         st_next.line_ctrl = ext_pin_irq_pkg::CTRL_W'(lane_merge(
            16'(st_reg.line_ctrl), wb_req.dat[15:0], wb_req.sel[1:0]));
      end
      if (wr_acc && hit_mask && wb_req.sel[0]) begin
         st_next.mask = wb_req.dat[ext_pin_irq_pkg::REQ_W-1:0];
      end

      // Arm flags read as one; any write to the request word with sel[0] set disarms all
      if (rd_acc && hit_req) begin
         st_next.armed = st_reg.armed | st_reg.rdata[ext_pin_irq_pkg::IRQ_LINES-1:0];
      end
      if (wr_req_hit) begin
         st_next.armed = '0;
      end

      // Sticky status; a new event wins over a read clear in the same clock
      st_next.req_prev = req_now;
      st_next.status   = st_reg.status;
      if (rd_acc && hit_status) begin
         st_next.status = st_reg.status & ~st_reg.rdata[ext_pin_irq_pkg::REQ_W-1:0];
      end
      st_next.status = st_next.status | event_vec;

      // Registered level interrupt
      st_next.irq = |(st_next.status & st_next.mask);
   end

   // State register; reset values are fixed constants
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_reg <= ext_pin_irq_pkg::MAIN_RESET;
      end else if (clk_en) begin
         st_reg <= st_next;
      end
   end

   // Outputs straight from flip-flops
   assign wb_rsp.ack = st_reg.ack;
   assign wb_rsp.dat = st_reg.rdata;
   assign irq_out    = st_reg.irq;

   default clocking main_cb @(posedge ref_clk);
   endclocking
   default disable iff (!arst_n || !clk_en);

   // Edge-mode test for line 0, used by two checks
   logic edge_mode0;
   assign edge_mode0 = ~st_reg.line_ctrl[1];

   sequence seq_read_flag0;
      rd_acc && hit_req && st_reg.rdata[0];
   endsequence

   sequence seq_clear0;
      wr_req_hit && !wb_req.dat[0] && st_reg.armed[0];
   endsequence

   a_sense_enable_reset: assert property (
      $rose(arst_n) |-> st_reg.sense == ext_pin_irq_pkg::SENSE_RESET &&
      st_reg.enable == ext_pin_irq_pkg::ENABLE_RESET)
      else $error("sense or enable not zero after reset");

   a_request_reset: assert property (
      $rose(arst_n) |-> req_now == ext_pin_irq_pkg::REQ_RESET)
      else $error("request word not zero after reset");

   a_pin_polarity_match: assert property (
      1'b1 |=> st_reg.grp_low == $past(|(st_reg.enable[7:0] &
      ~(port_irq_pin[7:0] ^ st_reg.sense[7:0]))))
      else $error("low group flag does not match pin polarity");

   a_disabled_pins_quiet: assert property (
      st_reg.enable == '0 |=> !st_reg.grp_low && !st_reg.grp_high)
      else $error("disabled pins raised a group flag");

   a_low_group_flag: assert property (
      |match_vec[7:0] |=> req_now[ext_pin_irq_pkg::REQ_LOW_GRP_BIT])
      else $error("low group request not shown in bit 7");

   a_high_group_flag: assert property (
      !(|match_vec[15:8]) |=> !req_now[ext_pin_irq_pkg::REQ_HIGH_GRP_BIT])
      else $error("high group bit set without a request");

   a_clear_after_read: assert property (
      seq_read_flag0 ##[2:8] seq_clear0 |-> clear_vec[0])
      else $error("armed zero write did not clear line 0");

   a_one_write_keeps: assert property (
      wr_req_hit && wb_req.dat[0] && line_flag[0] && edge_mode0 |=> line_flag[0])
      else $error("writing one changed line 0 flag");

   a_unarmed_clear_ignored: assert property (
      wr_req_hit && !st_reg.armed[0] && line_flag[0] && edge_mode0 |=> line_flag[0])
      else $error("zero write without prior read cleared line 0");

   // Read data was captured one edge before ack, so it shows the flags of then
   a_flag_reaches_word: assert property (
      rd_acc && hit_req |->
      wb_rsp.dat[ext_pin_irq_pkg::IRQ_LINES-1:0] == $past(line_flag))
      else $error("line flags not visible in the request word");

endmodule

`default_nettype wire

// ---- testbench/irq_source_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// Stand-in for the external request sources wired to the pins
module irq_source_model (
   input  wire logic                             ref_clk,
   output logic [ext_pin_irq_pkg::PORT_PINS-1:0] port_irq_pin,
   output logic [ext_pin_irq_pkg::IRQ_LINES-1:0] irq_line
);
   // Lines idle high, so the first thing a detector can see is a falling edge
   initial begin
      port_irq_pin = 16'h0000;
      irq_line     = 6'h3f;
   end

   // Pins move just after a clock edge, like a synchronous source
   task automatic set_port(input logic [15:0] v);
      @(posedge ref_clk);
      port_irq_pin <= v;
   endtask

   // Same for the IRQ lines; one call gives one step of the waveform
   task automatic set_line(input logic [5:0] v);
      @(posedge ref_clk);
      irq_line <= v;
   endtask
endmodule

`default_nettype wire

// ---- testbench/ext_pin_irq_detect_tb.sv ----
`timescale 1ns/1ps
`default_nettype none

module ext_pin_irq_detect_tb;
   logic                        ref_clk;      // 20 MHz bench clock
   logic                        arst_n;       // Async reset, active low
   logic                        clk_en;       // Held high except in t_freeze
   ext_pin_irq_pkg::wb_req_type wb_req;       // Bus request
   ext_pin_irq_pkg::wb_rsp_type wb_rsp;       // Bus answer
   logic [15:0]                 port_irq_pin; // Port pins from the sources
   logic [5:0]                  irq_line;     // IRQ lines from the sources
   logic                        irq_out;      // Interrupt output
   logic [31:0]                 rd;           // Last read data
   int                          n_fail;       // Mismatches
   int                          comparisons;  // Checks made

   irq_source_model src (
      .ref_clk      (ref_clk),
      .port_irq_pin (port_irq_pin),
      .irq_line     (irq_line)
   );

   ext_pin_irq_detect dut (
      .ref_clk      (ref_clk),
      .arst_n       (arst_n),
      .clk_en       (clk_en),
      .wb_req       (wb_req),
      .wb_rsp       (wb_rsp),
      .port_irq_pin (port_irq_pin),
      .irq_line     (irq_line),
      .irq_out      (irq_out)
   );

   // Clock: half period of 25 ns
   initial ref_clk = 1'b0;
   always #25 ref_clk = ~ref_clk;

   // Verdict and end of run; timeouts come here too
   task automatic complete_run;
      $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // Four-state compare so an unknown never matches
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Classic cycle: held until ack is sampled, then one idle cycle
   task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] sel);
      int n;
      wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: sel, dat: d};
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (wb_rsp.ack !== 1'b1 && n < 20);
      if (wb_rsp.ack !== 1'b1) begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, wb_rsp.ack, 1'b1);
         complete_run();
      end else begin
         rd = wb_rsp.dat;
         wb_req <= '0;
         @(posedge ref_clk);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d, 4'hf);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0, 4'hf);
      chk(rd, e);
   endtask

   // Reset values, plus an unmapped word that must read zero
   task automatic t_reset;
      rdc(ext_pin_irq_pkg::OFF_SENSE, 32'h0);
      rdc(ext_pin_irq_pkg::OFF_ENABLE, 32'h0);
      rdc(ext_pin_irq_pkg::OFF_REQ, 32'h0);
      rdc(8'h18, 32'h0);
   endtask

   // Group flags: pins 0,1 low-active, pin 8 high-active, pins 2-7 and 9-15 disabled
   task automatic t_port;
      logic [15:0] pins [3] = '{16'hffff, 16'h0000, 16'h00ff};
      logic [7:0]  exp  [3] = '{8'h40, 8'h80, 8'h00};
      bus(1'b1, ext_pin_irq_pkg::OFF_SENSE, 32'h0000_0100, 4'h3);
      wr(ext_pin_irq_pkg::OFF_ENABLE, 32'h0000_0103);
      rdc(ext_pin_irq_pkg::OFF_ENABLE, 32'h0000_0103);
      for (int i = 0; i < 3; i++) begin
         src.set_port(pins[i]);
         repeat (2) @(posedge ref_clk);
         rdc(ext_pin_irq_pkg::OFF_REQ, {24'h0, exp[i]});
      end
      // Only the low lane is written; the high byte keeps its bit
      bus(1'b1, ext_pin_irq_pkg::OFF_SENSE, 32'h0000_ffff, 4'h1);
      rdc(ext_pin_irq_pkg::OFF_SENSE, 32'h0000_01ff);
      wr(ext_pin_irq_pkg::OFF_ENABLE, 32'h0);
   endtask

   // Each line pulsed low then high; even lines falling, odd lines rising
   task automatic t_edge;
      logic [7:0] m;
      wr(ext_pin_irq_pkg::OFF_CTRL, 32'h0000_0444);
      rdc(ext_pin_irq_pkg::OFF_CTRL, 32'h0000_0444);
      for (int i = 0; i < 6; i++) begin
         m = 8'h01 << i;
         src.set_line(6'h3f & ~m[5:0]);
         src.set_line(6'h3f);
         repeat (3) @(posedge ref_clk);
         // A zero written without a prior read must not clear
         wr(ext_pin_irq_pkg::OFF_REQ, 32'h0);
         rdc(ext_pin_irq_pkg::OFF_REQ, {24'h0, m});
         wr(ext_pin_irq_pkg::OFF_REQ, 32'h0000_00ff);
         rdc(ext_pin_irq_pkg::OFF_REQ, {24'h0, m});
         wr(ext_pin_irq_pkg::OFF_REQ, {24'h0, ~m});
         rdc(ext_pin_irq_pkg::OFF_REQ, 32'h0);
      end
   endtask

   // Line 2 in low-level mode, line 0 in the reserved mode
   task automatic t_low;
      wr(ext_pin_irq_pkg::OFF_CTRL, 32'h0000_0023);
      // Lines 0 and 2 low, then only line 0 released; line 2 stays low
      src.set_line(6'h3a);
      src.set_line(6'h3b);
      repeat (3) @(posedge ref_clk);
      rdc(ext_pin_irq_pkg::OFF_REQ, 32'h0000_0004);
      wr(ext_pin_irq_pkg::OFF_REQ, 32'h0000_00fb);
      rdc(ext_pin_irq_pkg::OFF_REQ, 32'h0000_0004);
      src.set_line(6'h3f);
      repeat (3) @(posedge ref_clk);
      rdc(ext_pin_irq_pkg::OFF_REQ, 32'h0);
   endtask

   // Clock enable low: a pulse on lines 1 and 2 while frozen is never seen
   task automatic t_freeze;
      clk_en <= 1'b0;
      src.set_line(6'h39);
      src.set_line(6'h3f);
      repeat (2) @(posedge ref_clk);
      clk_en <= 1'b1;
      repeat (3) @(posedge ref_clk);
      rdc(ext_pin_irq_pkg::OFF_REQ, 32'h0);
   endtask

   // Sticky status, masking, level output and read-clear
   task automatic t_irq;
      rdc(ext_pin_irq_pkg::OFF_STATUS, 32'h0000_00ff);
      rdc(ext_pin_irq_pkg::OFF_STATUS, 32'h0);
      wr(ext_pin_irq_pkg::OFF_MASK, 32'h0000_0001);
      wr(ext_pin_irq_pkg::OFF_CTRL, 32'h0);
      src.set_line(6'h3d);
      repeat (4) @(posedge ref_clk);
      chk({31'h0, irq_out}, 32'h0);
      src.set_line(6'h3c);
      repeat (4) @(posedge ref_clk);
      chk({31'h0, irq_out}, 32'h1);
      rdc(ext_pin_irq_pkg::OFF_STATUS, 32'h0000_0003);
      chk({31'h0, irq_out}, 32'h0);
      src.set_line(6'h3f);
      rdc(ext_pin_irq_pkg::OFF_REQ, 32'h0000_0003);
      wr(ext_pin_irq_pkg::OFF_REQ, 32'h0000_00fc);
      rdc(ext_pin_irq_pkg::OFF_REQ, 32'h0);
   endtask

   // Second reset in mid-run returns written registers to zero
   task automatic t_rerst;
      arst_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      arst_n <= 1'b1;
      @(posedge ref_clk);
      rdc(ext_pin_irq_pkg::OFF_SENSE, 32'h0);
      rdc(ext_pin_irq_pkg::OFF_MASK, 32'h0);
      rdc(ext_pin_irq_pkg::OFF_REQ, 32'h0);
   endtask

   // Main sequence: 20-cycle reset, then the scenarios in order
   initial begin
      n_fail = 0;
      comparisons = 0;
      arst_n = 1'b0;
      clk_en = 1'b1;
      wb_req = '0;
      rd = 32'h0;
      repeat (20) @(posedge ref_clk);
      arst_n <= 1'b1;
      @(posedge ref_clk);
      t_reset();
      t_port();
      t_edge();
      t_low();
      t_freeze();
      t_irq();
      t_rerst();
      complete_run();
   end
endmodule

`default_nettype wire
